/* File: design/fiap_params.svh */
// Constants for the flash self-programming access block
`ifndef FIAP_PARAMS_SVH
`define FIAP_PARAMS_SVH

// Register byte offsets
`define FIAP_OFS_CTRL        8'h00
`define FIAP_OFS_CTRL2       8'h04
`define FIAP_OFS_ADDR_LOW    8'h08
`define FIAP_OFS_ADDR_HIGH   8'h0c
`define FIAP_OFS_DATA_LOW    8'h10
`define FIAP_OFS_DATA_HIGH   8'h14
`define FIAP_OFS_UNLOCK      8'h18
`define FIAP_OFS_STATUS      8'h1c
`define FIAP_OFS_MASK        8'h20

// Control register bit positions
`define FIAP_BIT_READ_START  0
`define FIAP_BIT_READ_EN     1
`define FIAP_BIT_WRITE_START 2
`define FIAP_BIT_ERASE_START 3
`define FIAP_BIT_UNLOCKED    7
`define FIAP_BIT_CLEAR_BUF   0

// Status bit positions
`define FIAP_ST_WRITE_DONE   0
`define FIAP_ST_READ_DONE    1
`define FIAP_ST_ERASE_DONE   2
`define FIAP_ST_CLEAR_DONE   3

// Reset values
`define FIAP_RST_BYTE        8'h00
`define FIAP_RST_ADDR        12'h000
`define FIAP_RST_STATUS      4'h0

// Unlock keys, values arbitrary
`define FIAP_KEY_FIRST       8'h5a
`define FIAP_KEY_SECOND      8'ha5

// Value left in a cleared buffer entry
`define FIAP_BUF_CLEAR       16'h0000

// Last word offset of a page
`define FIAP_LAST_OFFSET     5'h1f

`endif

/* File: design/fiap_pkg.sv */
// Types for the flash self-programming access block
package fiap_pkg;

   typedef enum logic [1:0] {
      FIAP_OP_READ,
      FIAP_OP_ERASE,
      FIAP_OP_PROG
   } fiap_op_t;

   typedef enum {
      FIAP_IDLE,
      FIAP_CLEAR,
      FIAP_ERASE,
      FIAP_PROG_FETCH,
      FIAP_PROG,
      FIAP_READ
   } fiap_state_t;

endpackage : fiap_pkg

/* File: design/fiap_wbuf.sv */
// Page write buffer memory with registered read data
`timescale 1ns/1ps
module fiap_wbuf #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic             hclk,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Write port
   always_ff @(posedge hclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge hclk) begin
      rd_data <= mem[rd_addr];
   end

endmodule : fiap_wbuf

/* File: design/fiap_top.sv */
// Flash self-programming access logic with AHB-Lite registers
`timescale 1ns/1ps
`include "fiap_params.svh"
module fiap_top #(
   parameter int WORDS = 32,
   parameter int OFS_W = 5
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   output logic             flash_req,
   output logic      [1:0]  flash_op,
   output logic      [11:0] flash_addr,
   output logic      [15:0] flash_wdata,
   input  wire logic [15:0] flash_rdata,
   input  wire logic        flash_done,
   input  wire logic        on_chip_debug_active,
   input  wire logic        in_circuit_programming_active,
   input  wire logic        prog_serial_data_in,
   output logic             prog_serial_data_out,
   output logic             prog_serial_data_oe,
   input  wire logic        prog_serial_clock_in,
   input  wire logic        serial_drive_data,
   input  wire logic        serial_drive_en,
   output logic             serial_data_sync,
   output logic             serial_clock_sync,
   input  wire logic        gpio_data_out,
   input  wire logic        gpio_data_oe,
   output logic             gpio_data_in,
   output logic             gpio_clock_in
);

   fiap_pkg::fiap_state_t state_reg;
   fiap_pkg::fiap_state_t state_next;

   logic [7:0]        addr_low_reg;
   logic [3:0]        addr_high_reg;
   logic [7:0]        data_low_reg;
   logic [7:0]        data_high_reg;
   logic              unlocked_reg;
   logic              key_half_reg;
   logic              read_en_reg;
   logic              read_busy_reg;
   logic              write_busy_reg;
   logic              erase_busy_reg;
   logic              clear_busy_reg;
   logic [3:0]        status_reg;
   logic [3:0]        mask_reg;
   logic [OFS_W-1:0]  idx_reg;
   logic              ph_write_reg;
   logic [7:0]        ph_addr_reg;
   logic [1:0]        sync1_reg;
   logic [1:0]        sync2_reg;
   logic [1:0]        sync3_reg;
   logic [1:0]        stable_reg;

   logic              addr_phase;
   logic              wr_ctrl;
   logic              wr_ctrl2;
   logic              wr_alow;
   logic              wr_ahigh;
   logic              wr_dlow;
   logic              wr_dhigh;
   logic              wr_unlock;
   logic              wr_status;
   logic              wr_mask;
   logic [7:0]        wbyte;
   logic              idle;
   logic              start_write;
   logic              start_read;
   logic              start_erase;
   logic              start_clear;
   logic              last_idx;
   logic              buf_load;
   logic              buf_wr_en;
   logic [OFS_W-1:0]  buf_wr_addr;
   logic [15:0]       buf_wr_data;
   logic [15:0]       buf_rd_data;
   logic [3:0]        ev;
   logic [31:0]       rd_mux;
   logic [11:0]       addr_full;
   logic              ser_mode;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_phase = hsel & htrans[1] & hready;
   assign wbyte      = hwdata[7:0];
   assign idle       = (state_reg == fiap_pkg::FIAP_IDLE);
   assign addr_full  = {addr_high_reg, addr_low_reg};

   // AHB address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_write_reg <= 1'b0;
         ph_addr_reg  <= 8'h00;
      end else begin
         ph_write_reg <= addr_phase & hwrite;
         ph_addr_reg  <= haddr[7:0];
      end
   end

   // Write strobe decode
   always_comb begin
      wr_ctrl   = 1'b0;
      wr_ctrl2  = 1'b0;
      wr_alow   = 1'b0;
      wr_ahigh  = 1'b0;
      wr_dlow   = 1'b0;
      wr_dhigh  = 1'b0;
      wr_unlock = 1'b0;
      wr_status = 1'b0;
      wr_mask   = 1'b0;
      if (!ph_write_reg) begin
         wr_ctrl = 1'b0;
      end else if (ph_addr_reg == `FIAP_OFS_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (ph_addr_reg == `FIAP_OFS_CTRL2) begin
         wr_ctrl2 = 1'b1;
      end else if (ph_addr_reg == `FIAP_OFS_ADDR_LOW) begin
         wr_alow = 1'b1;
      end else if (ph_addr_reg == `FIAP_OFS_ADDR_HIGH) begin
         wr_ahigh = 1'b1;
      end else if (ph_addr_reg == `FIAP_OFS_DATA_LOW) begin
         wr_dlow = 1'b1;
      end else if (ph_addr_reg == `FIAP_OFS_DATA_HIGH) begin
         wr_dhigh = 1'b1;
      end else if (ph_addr_reg == `FIAP_OFS_UNLOCK) begin
         wr_unlock = 1'b1;
      end else if (ph_addr_reg == `FIAP_OFS_STATUS) begin
         wr_status = 1'b1;
      end else if (ph_addr_reg == `FIAP_OFS_MASK) begin
         wr_mask = 1'b1;
      end
   end

   // Read data mux, unmapped reads as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (haddr[7:0] == `FIAP_OFS_CTRL) begin
         rd_mux[`FIAP_BIT_UNLOCKED]    = unlocked_reg;
         rd_mux[`FIAP_BIT_ERASE_START] = erase_busy_reg;
         rd_mux[`FIAP_BIT_WRITE_START] = write_busy_reg;
         rd_mux[`FIAP_BIT_READ_EN]     = read_en_reg;
         rd_mux[`FIAP_BIT_READ_START]  = read_busy_reg;
      end else if (haddr[7:0] == `FIAP_OFS_CTRL2) begin
         rd_mux[`FIAP_BIT_CLEAR_BUF] = clear_busy_reg;
      end else if (haddr[7:0] == `FIAP_OFS_ADDR_LOW) begin
         rd_mux[7:0] = addr_low_reg;
      end else if (haddr[7:0] == `FIAP_OFS_ADDR_HIGH) begin
         rd_mux[3:0] = addr_high_reg;
      end else if (haddr[7:0] == `FIAP_OFS_DATA_LOW) begin
         rd_mux[7:0] = data_low_reg;
      end else if (haddr[7:0] == `FIAP_OFS_DATA_HIGH) begin
         rd_mux[7:0] = data_high_reg;
      end else if (haddr[7:0] == `FIAP_OFS_STATUS) begin
         rd_mux[3:0] = status_reg;
      end else if (haddr[7:0] == `FIAP_OFS_MASK) begin
         rd_mux[3:0] = mask_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= rd_mux;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unlocked_reg <= 1'b0;
         key_half_reg <= 1'b0;
      end else if (wr_unlock) begin
         key_half_reg <= (wbyte == `FIAP_KEY_FIRST);
         if (key_half_reg && wbyte == `FIAP_KEY_SECOND) begin
            unlocked_reg <= 1'b1;
         end
      end else if (wr_ctrl && !wbyte[`FIAP_BIT_UNLOCKED]) begin
         unlocked_reg <= 1'b0;
      end
   end

   // Operation start requests, one at a time
   // locked write ignored
   assign start_write = wr_ctrl & wbyte[`FIAP_BIT_WRITE_START] & idle
                        & unlocked_reg;
   assign start_erase = wr_ctrl & wbyte[`FIAP_BIT_ERASE_START] & idle
                        & unlocked_reg & !start_write;
   assign start_read  = wr_ctrl & wbyte[`FIAP_BIT_READ_START] & idle
                        & wbyte[`FIAP_BIT_READ_EN] & !start_write
                        & !start_erase;
   assign start_clear = wr_ctrl2 & wbyte[`FIAP_BIT_CLEAR_BUF] & idle;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         read_en_reg <= 1'b0;
      end else if (wr_ctrl) begin
         read_en_reg <= wbyte[`FIAP_BIT_READ_EN];
      end
   end

   assign last_idx = (idx_reg == OFS_W'(WORDS - 1));

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         fiap_pkg::FIAP_IDLE: begin
            if (start_write) begin
               state_next = fiap_pkg::FIAP_PROG_FETCH;
            end else if (start_erase) begin
               state_next = fiap_pkg::FIAP_ERASE;
            end else if (start_read) begin
               state_next = fiap_pkg::FIAP_READ;
            end else if (start_clear) begin
               state_next = fiap_pkg::FIAP_CLEAR;
            end
         end
         fiap_pkg::FIAP_CLEAR: begin
            if (last_idx) begin
               state_next = fiap_pkg::FIAP_IDLE;
            end
         end
         fiap_pkg::FIAP_ERASE, fiap_pkg::FIAP_READ: begin
            if (flash_done) begin
               state_next = fiap_pkg::FIAP_IDLE;
            end
         end
         fiap_pkg::FIAP_PROG_FETCH: begin
            state_next = fiap_pkg::FIAP_PROG;
         end
         fiap_pkg::FIAP_PROG: begin
            if (flash_done) begin
               state_next = last_idx ? fiap_pkg::FIAP_CLEAR
                                     : fiap_pkg::FIAP_PROG_FETCH;
            end
         end
         default: begin
            state_next = fiap_pkg::FIAP_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= fiap_pkg::FIAP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // walk all words of a page
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx_reg <= '0;
      end else if (idle) begin
         idx_reg <= '0;
      end else if (state_reg == fiap_pkg::FIAP_CLEAR) begin
         idx_reg <= last_idx ? '0 : idx_reg + 1'b1;
      end else if (state_reg == fiap_pkg::FIAP_PROG && flash_done) begin
         idx_reg <= last_idx ? '0 : idx_reg + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         write_busy_reg <= 1'b0;
      end else if (start_write) begin
         write_busy_reg <= 1'b1;
      end else if (write_busy_reg && state_next == fiap_pkg::FIAP_IDLE) begin
         write_busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         read_busy_reg <= 1'b0;
      end else if (start_read) begin
         read_busy_reg <= 1'b1;
      end else if (state_reg == fiap_pkg::FIAP_READ && flash_done) begin
         read_busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         erase_busy_reg <= 1'b0;
      end else if (start_erase) begin
         erase_busy_reg <= 1'b1;
      end else if (state_reg == fiap_pkg::FIAP_ERASE && flash_done) begin
         erase_busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clear_busy_reg <= 1'b0;
      end else if (start_clear) begin
         clear_busy_reg <= 1'b1;
      end else if (state_reg == fiap_pkg::FIAP_CLEAR && last_idx) begin
         clear_busy_reg <= 1'b0;
      end
   end

   assign buf_load = wr_dhigh & unlocked_reg & idle;

   // Address registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_low_reg  <= `FIAP_RST_BYTE;
         addr_high_reg <= 4'(`FIAP_RST_ADDR >> 8);
      end else if (wr_alow) begin
         addr_low_reg <= wbyte;
      end else if (wr_ahigh) begin
         addr_high_reg <= wbyte[3:0];
      end else if (buf_load &&
                   addr_low_reg[OFS_W-1:0] != `FIAP_LAST_OFFSET) begin
         addr_low_reg[OFS_W-1:0] <= addr_low_reg[OFS_W-1:0] + 1'b1;
      end
   end

   // Data registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_low_reg  <= `FIAP_RST_BYTE;
         data_high_reg <= `FIAP_RST_BYTE;
      end else if (state_reg == fiap_pkg::FIAP_READ && flash_done) begin
         data_low_reg  <= flash_rdata[7:0];
         data_high_reg <= flash_rdata[15:8];
      end else if (wr_dlow) begin
         data_low_reg <= wbyte;
      end else if (wr_dhigh) begin
         data_high_reg <= wbyte;
      end
   end

   assign buf_wr_en   = buf_load | (state_reg == fiap_pkg::FIAP_CLEAR);
   assign buf_wr_addr = buf_load ? addr_low_reg[OFS_W-1:0] : idx_reg;
   assign buf_wr_data = buf_load ? {wbyte, data_low_reg}
                                 : `FIAP_BUF_CLEAR;

   fiap_wbuf #(
      .WIDTH (16),
      .DEPTH (WORDS),
      .AW    (OFS_W)
   ) u_wbuf (
      .hclk    (hclk),
      .wr_en   (buf_wr_en),
      .wr_addr (buf_wr_addr),
      .wr_data (buf_wr_data),
      .rd_addr (idx_reg + OFS_W'(state_reg == fiap_pkg::FIAP_PROG
                                 && flash_done)),
      .rd_data (buf_rd_data)
   );

   // Flash macro request, page and word address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flash_req   <= 1'b0;
         flash_op    <= fiap_pkg::FIAP_OP_READ;
         flash_addr  <= `FIAP_RST_ADDR;
         flash_wdata <= 16'h0000;
      end else if (flash_done) begin
         flash_req <= 1'b0;
      end else if (state_next == fiap_pkg::FIAP_READ && idle) begin
         flash_req  <= 1'b1;
         flash_op   <= fiap_pkg::FIAP_OP_READ;
         flash_addr <= addr_full;
      end else if (state_next == fiap_pkg::FIAP_ERASE && idle) begin
         flash_req  <= 1'b1;
         flash_op   <= fiap_pkg::FIAP_OP_ERASE;
         flash_addr <= {addr_full[11:OFS_W], OFS_W'(0)};
      end else if (state_reg == fiap_pkg::FIAP_PROG_FETCH) begin
         flash_req   <= 1'b1;
         flash_op    <= fiap_pkg::FIAP_OP_PROG;
         flash_addr  <= {addr_full[11:OFS_W], idx_reg};
         flash_wdata <= buf_rd_data;
      end
   end

   // Completion events
   assign ev[`FIAP_ST_WRITE_DONE] = write_busy_reg
                                    & (state_next == fiap_pkg::FIAP_IDLE);
   assign ev[`FIAP_ST_READ_DONE]  = (state_reg == fiap_pkg::FIAP_READ)
                                    & flash_done;
   assign ev[`FIAP_ST_ERASE_DONE] = (state_reg == fiap_pkg::FIAP_ERASE)
                                    & flash_done;
   assign ev[`FIAP_ST_CLEAR_DONE] = clear_busy_reg
                                    & (state_reg == fiap_pkg::FIAP_CLEAR)
                                    & last_idx;

   // Sticky status, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= `FIAP_RST_STATUS;
      end else begin
         status_reg <= (status_reg & ~(wr_status ? wbyte[3:0] : 4'h0)) | ev;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_reg <= `FIAP_RST_STATUS;
      end else if (wr_mask) begin
         mask_reg <= wbyte[3:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_reg & mask_reg);
      end
   end

   generate
      for (genvar i = 0; i < 2; i++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               sync1_reg[i]  <= 1'b0;
               sync2_reg[i]  <= 1'b0;
               sync3_reg[i]  <= 1'b0;
               stable_reg[i] <= 1'b0;
            end else begin
               sync1_reg[i] <= (i == 0) ? prog_serial_data_in
                                        : prog_serial_clock_in;
               sync2_reg[i] <= sync1_reg[i];
               sync3_reg[i] <= sync2_reg[i];
               if (sync2_reg[i] == sync3_reg[i]) begin
                  stable_reg[i] <= sync3_reg[i];
               end
            end
         end
      end
   endgenerate

   // serial engine owns the shared pins
   assign ser_mode = on_chip_debug_active | in_circuit_programming_active;
   assign serial_data_sync  = stable_reg[0];
   assign serial_clock_sync = stable_reg[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prog_serial_data_out <= 1'b0;
         prog_serial_data_oe  <= 1'b0;
         gpio_data_in         <= 1'b0;
         gpio_clock_in        <= 1'b0;
      end else if (ser_mode) begin
         prog_serial_data_out <= serial_drive_data;
         prog_serial_data_oe  <= serial_drive_en;
         gpio_data_in         <= 1'b0;
         gpio_clock_in        <= 1'b0;
      end else begin
         prog_serial_data_out <= gpio_data_out;
         prog_serial_data_oe  <= gpio_data_oe;
         gpio_data_in         <= stable_reg[0];
         gpio_clock_in        <= stable_reg[1];
      end
   end

endmodule : fiap_top

/* File: test/fiap_flash_model.sv */
// Flash macro model answering promptly or slowly
`timescale 1ns/1ps
module fiap_flash_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        slow,
   input  wire logic        flash_req,
   input  wire logic [1:0]  flash_op,
   input  wire logic [11:0] flash_addr,
   input  wire logic [15:0] flash_wdata,
   output logic      [15:0] flash_rdata,
   output logic             flash_done
);
   logic [15:0] mem [4096];
   logic [3:0]  wait_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {flash_done, wait_reg, flash_rdata} <= '0;
      end else begin
         flash_rdata <= ~flash_rdata;
         flash_done  <= 1'b0;
         if (flash_done) begin
            wait_reg <= 4'h0;
         end else if (flash_req) begin
            wait_reg <= wait_reg + 4'h1;
            if (wait_reg >= (slow ? 4'h6 : 4'h0)) begin
               flash_done  <= 1'b1;
               flash_rdata <= mem[flash_addr];
               if (flash_op == 2'h1)
                  for (int i = 0; i < 32; i++)
                     mem[{flash_addr[11:5], 5'(i)}] <= 16'hffff;
               if (flash_op == 2'h2)
                  mem[flash_addr] <= mem[flash_addr] & flash_wdata;
            end
         end
      end
   end
endmodule : fiap_flash_model

/* File: test/fiap_top_sva.sv */
// Checker of flash request, bus answer and pin sharing
`timescale 1ns/1ps
module fiap_top_sva #(
   parameter int WORDS = 32,
   parameter int OFS_W = 5
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        flash_req,
   input wire logic [1:0]  flash_op,
   input wire logic [11:0] flash_addr,
   input wire logic [15:0] flash_wdata,
   input wire logic        flash_done,
   input wire logic        on_chip_debug_active,
   input wire logic        in_circuit_programming_active,
   input wire logic        serial_drive_data,
   input wire logic        serial_drive_en,
   input wire logic        prog_serial_data_out,
   input wire logic        prog_serial_data_oe,
   input wire logic        gpio_data_in,
   input wire logic        gpio_clock_in
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [11:0] last_addr_reg;
   logic [1:0]  last_op_reg;
   wire  serial_mode = on_chip_debug_active | in_circuit_programming_active;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_addr_reg <= 12'h000;
         last_op_reg   <= 2'h0;
      end else if (flash_done) begin
         last_addr_reg <= flash_addr;
         last_op_reg   <= flash_op;
      end
   end
   sequence s_prog_start;
      $rose(flash_req) && flash_op == fiap_pkg::FIAP_OP_PROG;
   endsequence
   sequence s_erase_start;
      $rose(flash_req) && flash_op == fiap_pkg::FIAP_OP_ERASE;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   a_req_release: assert property (flash_req && flash_done |=> !flash_req)
      else $error("request held after done");
   a_req_steady: assert property (flash_req && !flash_done |=>
      flash_req && $stable(flash_addr) && $stable(flash_op)
      && $stable(flash_wdata)) else $error("request changed");
   a_prog_order: assert property (s_prog_start
      ##0 flash_addr[OFS_W-1:0] != '0 |-> last_op_reg == 2'h2
      && flash_addr == last_addr_reg + 12'h001) else $error("word order");
   a_erase_base: assert property (s_erase_start |->
      flash_addr[OFS_W-1:0] == '0) else $error("erase not at page base");
   a_op_legal: assert property (flash_req |-> flash_op != 2'h3)
      else $error("bad flash op");
   a_pins_blocked: assert property (serial_mode |=>
      !gpio_data_in && !gpio_clock_in) else $error("shared pin leaked");
   a_serial_drive: assert property (serial_mode && serial_drive_en |=>
      prog_serial_data_oe && prog_serial_data_out == $past(serial_drive_data))
      else $error("serial pin not driven");
endmodule : fiap_top_sva
bind fiap_top fiap_top_sva #(.WORDS(WORDS), .OFS_W(OFS_W)) i_fiap_top_sva (
   .hclk, .hresetn, .hreadyout, .hresp, .flash_req, .flash_op, .flash_addr,
   .flash_wdata, .flash_done, .on_chip_debug_active,
   .in_circuit_programming_active, .serial_drive_data, .serial_drive_en,
   .prog_serial_data_out, .prog_serial_data_oe, .gpio_data_in,
   .gpio_clock_in);

/* File: test/flash_iap_page_access_tb.sv */
// Self-checking bench for the flash access block
`timescale 1ns/1ps
`include "fiap_params.svh"
module flash_iap_page_access_tb;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0, gpio_data_in;
   logic on_chip_debug_active = 0, in_circuit_programming_active = 0;
   logic prog_serial_data_in = 0, prog_serial_clock_in = 0, gpio_clock_in;
   logic serial_drive_data = 0, serial_drive_en = 0;
   logic gpio_data_out = 0, gpio_data_oe = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0, flash_op;
   logic [11:0] flash_addr;
   logic [15:0] flash_wdata, flash_rdata, rnd = 16'd35, pin_rnd = 16'd35;
   logic [15:0] exp_mem [32], pg;
   logic hreadyout, hresp, irq, flash_req, flash_done, prog_serial_data_out;
   logic prog_serial_data_oe, serial_data_sync, serial_clock_sync;
   int err_total = 0, n_checks = 0;
   fiap_top i_fiap_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .irq, .flash_req, .flash_op, .flash_addr, .flash_wdata, .flash_rdata,
      .flash_done, .on_chip_debug_active, .in_circuit_programming_active,
      .prog_serial_data_in, .prog_serial_data_out, .prog_serial_data_oe,
      .prog_serial_clock_in, .serial_drive_data, .serial_drive_en,
      .serial_data_sync, .serial_clock_sync, .gpio_data_out, .gpio_data_oe,
      .gpio_data_in, .gpio_clock_in);
   fiap_flash_model i_fiap_flash_model (.hclk, .hresetn, .slow, .flash_req,
      .flash_op, .flash_addr, .flash_wdata, .flash_rdata, .flash_done);
   always #10 hclk = ~hclk;
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return x[0] ? (x >> 1) ^ 16'hb400 : x >> 1;
   endfunction : lfsr
   function automatic logic [4:0] next_ofs(input int i);
      return (i < 31) ? 5'(i + 1) : `FIAP_LAST_OFFSET;
   endfunction : next_ofs
   always @(posedge hclk) begin
      pin_rnd <= lfsr(pin_rnd);
      {prog_serial_data_in, prog_serial_clock_in, serial_drive_data,
       serial_drive_en, gpio_data_out, gpio_data_oe} <= pin_rnd[5:0];
   end
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic poll(input logic [7:0] a, input int b);
      for (int k = 0; k < 400; k++) begin
         bus(0, a, 0);
         if (rd[b] === 1'b0) return;
      end
      chk(rd, 0);
   endtask : poll
   task automatic page(input logic [6:0] p, input logic fill);
      bus(1, `FIAP_OFS_ADDR_HIGH, {28'h0, p[6:3]});
      bus(1, `FIAP_OFS_ADDR_LOW, {24'h0, p[2:0], 5'h00});
      bus(1, `FIAP_OFS_CTRL, 32'h88);
      poll(`FIAP_OFS_CTRL, 3);
      chk({31'h0, irq}, 0);
      for (int i = 0; i < 32 && fill; i++) begin
         rnd = lfsr(rnd);
         exp_mem[i] = rnd;
         bus(1, `FIAP_OFS_DATA_LOW, {24'h0, rnd[7:0]});
         bus(1, `FIAP_OFS_DATA_HIGH, {24'h0, rnd[15:8]});
         bus(0, `FIAP_OFS_ADDR_LOW, 0);
         chk(rd, {24'h0, p[2:0], next_ofs(i)});
      end
      bus(1, `FIAP_OFS_CTRL, 32'h84);
      bus(0, `FIAP_OFS_CTRL, 0);
      chk(rd, 32'h84);
      poll(`FIAP_OFS_CTRL, 2);
      chk({31'h0, irq}, 1);
      bus(1, `FIAP_OFS_STATUS, 32'h1);
      bus(0, `FIAP_OFS_STATUS, 0);
      chk({31'h0, irq}, 0);
      for (int i = 0; i < 32; i++)
         chk(i_fiap_flash_model.mem[{p, 5'(i)}], fill ? exp_mem[i] : 0);
   endtask : page
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20000) @(posedge hclk);
      $display("[ERR] %0t watchdog", $time);
      err_total++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(0, 8'h3c, 0);
      chk(rd, 0);
      bus(1, `FIAP_OFS_DATA_HIGH, 32'h12);
      bus(1, `FIAP_OFS_CTRL, 32'h04);
      bus(0, `FIAP_OFS_ADDR_LOW, 0);
      chk(rd, 0);
      bus(0, `FIAP_OFS_CTRL, 0);
      chk(rd, 0);
      bus(1, `FIAP_OFS_UNLOCK, `FIAP_KEY_FIRST);
      bus(1, `FIAP_OFS_UNLOCK, `FIAP_KEY_SECOND);
      bus(0, `FIAP_OFS_CTRL, 0);
      chk(rd, 32'h80);
      $display("lock test done");
      bus(1, `FIAP_OFS_MASK, 32'h1);
      pg = rnd;
      page(pg[6:0], 1);
      slow <= 1'b1;
      page(pg[6:0] ^ 7'h40, 0);
      $display("page test done");
      bus(1, `FIAP_OFS_ADDR_HIGH, {28'h0, pg[6:3]});
      bus(1, `FIAP_OFS_ADDR_LOW, {24'h0, pg[2:0], 5'h07});
      bus(1, `FIAP_OFS_CTRL, 32'h81);
      bus(0, `FIAP_OFS_CTRL, 0);
      chk(rd, 32'h80);
      bus(1, `FIAP_OFS_CTRL, 32'h83);
      poll(`FIAP_OFS_CTRL, 0);
      bus(0, `FIAP_OFS_DATA_LOW, 0);
      chk(rd, {24'h0, exp_mem[7][7:0]});
      bus(0, `FIAP_OFS_DATA_HIGH, 0);
      chk(rd, {24'h0, exp_mem[7][15:8]});
      bus(1, `FIAP_OFS_CTRL2, 32'h1);
      poll(`FIAP_OFS_CTRL2, 0);
      bus(0, `FIAP_OFS_STATUS, 0);
      chk({31'h0, rd[3]}, 1);
      $display("read test done");
      on_chip_debug_active <= 1'b1;
      repeat (3) @(posedge hclk);
      chk({30'h0, gpio_data_in, gpio_clock_in}, 0);
      {on_chip_debug_active, in_circuit_programming_active} <= 2'b01;
      repeat (20) @(posedge hclk);
      $display("pin test done");
      end_of_test;
   end
endmodule : flash_iap_page_access_tb
